/* inc/swcrb_defs.svh */
// register offsets, field positions, reset values and timing counts of the switch control bank
`ifndef SWCRB_DEFS_SVH
`define SWCRB_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SWCRB_OFS_CHANNEL_SELECT_CTRL    8'h00
`define SWCRB_OFS_LINK_OUTPUT_CTRL       8'h01
`define SWCRB_OFS_LINK_INPUT_CTRL        8'h02
`define SWCRB_OFS_INPUT_TERMINATION_CTRL 8'h03
`define SWCRB_OFS_AUX_BUFFER_ENABLES     8'h04
`define SWCRB_OFS_HOTPLUG_PULSE_WIDTH    8'h05

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SWCRB_RST_CHANNEL_SELECT_CTRL    3'h0
`define SWCRB_RST_LINK_OUTPUT_CTRL       4'h7
`define SWCRB_RST_LINK_INPUT_CTRL        2'h2
`define SWCRB_RST_INPUT_TERMINATION_CTRL 8'h0f
`define SWCRB_RST_AUX_BUFFER_ENABLES     3'h7
`define SWCRB_RST_HOTPLUG_PULSE_WIDTH    8'h05

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SWCRB_BIT_CHANNEL_SOURCE_SEL     2
`define SWCRB_BIT_OUTPUT_GATE_SOURCE     3
`define SWCRB_BIT_OUTPUT_ENABLE          2
`define SWCRB_BIT_OUTPUT_CURRENT_LEVEL   1
`define SWCRB_BIT_OUTPUT_TERMINATION_ON  0
`define SWCRB_BIT_EQUALIZER_BOOST_SEL    1
`define SWCRB_BIT_INPUT_POLARITY_INVERT  0
`define SWCRB_BIT_DISPLAY_DATA_BUFFER_ON 1
`define SWCRB_BIT_CONSUMER_CTRL_BUFFER_ON 0
`define SWCRB_TERM_MODE_MANUAL           4'hf

// ----------------------------------------------------------------------------
// serial address and timing
// ----------------------------------------------------------------------------
`define SWCRB_I2C_ADDR_UPPER             5'h12
`define SWCRB_CLK_HZ                     25000000
`define SWCRB_HOTPLUG_STEP_MS            24
`define SWCRB_HOTPLUG_STEP_CYCLES        ((`SWCRB_HOTPLUG_STEP_MS * `SWCRB_CLK_HZ) / 1000)

`endif

/* inc/swcrb_pkg.sv */
// types shared by the switch control register bank
package swcrb_pkg;

	typedef enum logic [2:0] {
		SWCRB_IDLE,
		SWCRB_RX,
		SWCRB_ACK,
		SWCRB_TX,
		SWCRB_TXACK
	} swcrb_i2c_e;

	// byte position inside a transfer
	typedef enum logic [1:0] {
		SWCRB_BYTE_ADDR,
		SWCRB_BYTE_PTR,
		SWCRB_BYTE_DATA
	} swcrb_byte_e;

	// controls handed to the analogue paths
	typedef struct packed {
		logic [1:0] active_input;
		logic       output_enable;
		logic       output_current_level;
		logic       output_termination_on;
		logic       equalizer_boost_sel;
		logic       input_polarity_invert;
		logic [3:0] input_termination_on;
		logic       display_data_buffer_on;
		logic       consumer_control_buffer_on;
	} swcrb_link_s;

	typedef struct packed {
		swcrb_i2c_e  st;
		swcrb_byte_e kind;
		logic [3:0]  cnt;
		logic        rw;
		logic [7:0]  shift;
		logic [7:0]  ptr;
		logic        scl_prev;
		logic        sda_prev;
		logic        drive_low;
		logic [2:0]  chan;
		logic [3:0]  outc;
		logic [1:0]  inc;
		logic [7:0]  term;
		logic [2:0]  aux;
		logic [7:0]  pw;
		logic [1:0]  prev_ch;
		logic        hp_start;
		swcrb_link_s link;
	} swcrb_state_s;

	typedef struct packed {
		logic        active;
		logic [7:0]  left;
		logic [23:0] cnt;
	} swcrb_timer_s;

endpackage

/* rtl/swcrb_hotplug_timer.sv */
// hot-plug low pulse timer counting whole steps
`timescale 1ns/10ps
module swcrb_hotplug_timer #(
	parameter int STEP_CYCLES = 600000
) (
	input  wire logic       clock,   // system clock
	input  wire logic       reset_n, // asynchronous reset, active low
	input  wire logic       start,   // one-cycle pulse: effective input changed
	input  wire logic [7:0] steps,   // pulse length in steps
	output logic            low      // high while the hot-plug lines are pulled low
);
	swcrb_pkg::swcrb_timer_s s_q;
	swcrb_pkg::swcrb_timer_s s_d;

	always_comb begin
		s_d = s_q;
		if (start) begin
			// a new switch restarts the pulse from full length
			s_d.active = (steps != 8'h00);                               // [R13]
			s_d.left   = steps;                                          // [R19]
			s_d.cnt    = '0;
		end else if (s_q.active) begin
			if (s_q.cnt == 24'(STEP_CYCLES - 1)) begin
				s_d.cnt  = '0;
				s_d.left = s_q.left - 8'h01;
				if (s_q.left == 8'h01) begin
					s_d.active = 1'b0;                                   // [R13]
				end
			end else begin
				s_d.cnt = s_q.cnt + 24'h000001;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign low = s_q.active;
endmodule

/* rtl/swcrb_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module swcrb_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,   // system clock
	input  wire logic         reset_n, // asynchronous reset, active low
	input  wire logic [W-1:0] d,       // asynchronous pin levels
	output logic      [W-1:0] q        // synchronised levels
);
	logic [2*W-1:0] s_q;
	logic [2*W-1:0] s_d;

	always_comb begin
		s_d = {s_q[W-1:0], d};
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q[2*W-1:W];
endmodule

/* rtl/swcrb_top.sv */
// switch control register bank with its serial slave and control decode
//
// Function
// (R1) channel source 0: select pins choose the active input, register field ignored.
// (R2) channel source 1: register field 00..11 chooses input A..D.
// (R3) output gate source picks pin (0) or register bit (1) for output enable.
// (R4) with register source, output-enable bit 0 disables, 1 enables the output.
// (R5) output current bit: 0 gives 10 mA, 1 gives 20 mA.
// (R6) output termination bit: 0 off, 1 on.
// (R7) equalizer bit: 0 gives 6 dB, 1 gives 18 dB boost.
// (R8) polarity bit: 0 standard, 1 inverted input polarity.
// (R9) termination mode field: 0000 automatic, 1111 manual.
// (R10) manual mode: mask bits 0..3 switch termination of inputs A..D.
// (R11) display-data buffer bit: 0 off, 1 on; reserved bit 2 written as 1.
// (R12) consumer-control buffer bit: 0 off, 1 on.
// (R13) hot-plug low pulse lasts pulse-width field times 24 ms.
// (R14) on a channel switch hot-plug lines pulled low, otherwise released.
// (R15) automatic termination: only the selected input is terminated.
// (R16) reset pin low restores every register default.
// (R17) answers seven-bit address 10010 followed by the two strap pins.
// (R18) unused bits ignore writes and read zero.
// (R19) pulse starts on every effective input change, counts whole 24 ms steps.
`timescale 1ns/10ps
`include "swcrb_defs.svh"
module swcrb_top #(
	parameter int STEP_CYCLES = `SWCRB_HOTPLUG_STEP_CYCLES
) (
	input  wire logic                  clock,        // system clock, 25 MHz
	input  wire logic                  reset_n,      // reset pin, active low
	input  wire logic                  scl_i,        // serial clock pin level
	input  wire logic                  sda_i,        // serial data pin level
	output logic                       sda_o,        // serial data drive value
	output logic                       sda_oe,       // serial data drive enable
	input  wire logic [1:0]            addr_strap,   // address strap pins
	input  wire logic [1:0]            sel_pins,     // parallel input select pins
	input  wire logic                  out_en_pin,   // parallel output enable pin
	output swcrb_pkg::swcrb_link_s     link,         // controls to the video paths
	output logic [3:0]                 hotplug_o,    // hot-plug drive values A..D
	output logic [3:0]                 hotplug_oe    // hot-plug drive enables A..D
);
	// ------------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------------
	logic [6:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic [1:0] strap_s;
	logic [1:0] sel_s;
	logic       oen_s;
	logic       hp_low;

	swcrb_sync #(
		.W (7)
	) u_sync (
		.clock   (clock),
		.reset_n (reset_n),
		.d       ({scl_i, sda_i, addr_strap, sel_pins, out_en_pin}),
		.q       (pins_s)
	);

	assign scl_s   = pins_s[6];
	assign sda_s   = pins_s[5];
	assign strap_s = pins_s[4:3];
	assign sel_s   = pins_s[2:1];
	assign oen_s   = pins_s[0];

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	swcrb_pkg::swcrb_state_s s_q;
	swcrb_pkg::swcrb_state_s s_d;

	// read view: unused bits are not stored, so they read back zero
	function automatic logic [7:0] read_reg(input swcrb_pkg::swcrb_state_s s,
		input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`SWCRB_OFS_CHANNEL_SELECT_CTRL:    r = {5'h00, s.chan};   // [R18]
			`SWCRB_OFS_LINK_OUTPUT_CTRL:       r = {4'h0, s.outc};    // [R18]
			`SWCRB_OFS_LINK_INPUT_CTRL:        r = {6'h00, s.inc};    // [R18]
			`SWCRB_OFS_INPUT_TERMINATION_CTRL: r = s.term;
			`SWCRB_OFS_AUX_BUFFER_ENABLES:     r = {5'h00, s.aux};    // [R18]
			`SWCRB_OFS_HOTPLUG_PULSE_WIDTH:    r = s.pw;
			default:                           r = 8'h00;
		endcase
		return r;
	endfunction

	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic [1:0] eff_ch;
	logic       manual_term;
	logic [3:0] auto_term;
	logic [7:0] rd_byte;

	assign scl_rise   = scl_s && !s_q.scl_prev;
	assign scl_fall   = !scl_s && s_q.scl_prev;
	assign start_cond = scl_s && s_q.scl_prev && s_q.sda_prev && !sda_s;
	assign stop_cond  = scl_s && s_q.scl_prev && !s_q.sda_prev && sda_s;

	always_comb begin
		s_d          = s_q;
		s_d.scl_prev = scl_s;
		s_d.sda_prev = sda_s;
		s_d.hp_start = 1'b0;
		// read byte at the pointer; a select on a function result is not portable
		rd_byte      = read_reg(s_q, s_q.ptr);

		// --------------------------------------------------------------------
		// serial slave
		// --------------------------------------------------------------------
		if (start_cond) begin
			// a start or repeated start always begins a new address byte
			s_d.st        = swcrb_pkg::SWCRB_RX;
			s_d.kind      = swcrb_pkg::SWCRB_BYTE_ADDR;
			s_d.cnt       = 4'h0;
			s_d.drive_low = 1'b0;
		end else if (stop_cond) begin
			s_d.st        = swcrb_pkg::SWCRB_IDLE;
			s_d.drive_low = 1'b0;
		end else begin
			case (s_q.st)
				swcrb_pkg::SWCRB_IDLE: begin
					s_d.drive_low = 1'b0;
				end
				swcrb_pkg::SWCRB_RX: begin
					if (scl_rise) begin
						s_d.shift = {s_q.shift[6:0], sda_s};
						s_d.cnt   = s_q.cnt + 4'h1;
					end else if (scl_fall && s_q.cnt == 4'h8) begin
						s_d.st        = swcrb_pkg::SWCRB_ACK;
						s_d.drive_low = 1'b1;
						case (s_q.kind)
							swcrb_pkg::SWCRB_BYTE_ADDR: begin
								s_d.rw = s_q.shift[0];
								if (s_q.shift[7:1] != {`SWCRB_I2C_ADDR_UPPER, strap_s}) begin
									// not our address: stay off the bus until next start
									s_d.st        = swcrb_pkg::SWCRB_IDLE;        // [R17]
									s_d.drive_low = 1'b0;
								end
							end
							swcrb_pkg::SWCRB_BYTE_PTR: begin
								s_d.ptr = s_q.shift;
							end
							swcrb_pkg::SWCRB_BYTE_DATA: begin
								// writes to unmapped offsets are acknowledged and dropped
								case (s_q.ptr)
									`SWCRB_OFS_CHANNEL_SELECT_CTRL:
										s_d.chan = s_q.shift[2:0];              // [R18]
									`SWCRB_OFS_LINK_OUTPUT_CTRL:
										s_d.outc = s_q.shift[3:0];              // [R18]
									`SWCRB_OFS_LINK_INPUT_CTRL:
										s_d.inc = s_q.shift[1:0];               // [R18]
									`SWCRB_OFS_INPUT_TERMINATION_CTRL:
										s_d.term = s_q.shift;
									`SWCRB_OFS_AUX_BUFFER_ENABLES:
										s_d.aux = s_q.shift[2:0];               // [R11]
									`SWCRB_OFS_HOTPLUG_PULSE_WIDTH:
										s_d.pw = s_q.shift;
									default: begin
									end
								endcase
								s_d.ptr = s_q.ptr + 8'h01;
							end
							default: begin
								s_d.st        = swcrb_pkg::SWCRB_IDLE;
								s_d.drive_low = 1'b0;
							end
						endcase
					end
				end
				swcrb_pkg::SWCRB_ACK: begin
					if (scl_fall) begin
						s_d.cnt = 4'h0;
						if (s_q.kind == swcrb_pkg::SWCRB_BYTE_ADDR && s_q.rw) begin
							s_d.st        = swcrb_pkg::SWCRB_TX;
							s_d.shift     = rd_byte;
							s_d.ptr       = s_q.ptr + 8'h01;
							s_d.drive_low = !rd_byte[7];
						end else begin
							s_d.st        = swcrb_pkg::SWCRB_RX;
							s_d.drive_low = 1'b0;
							if (s_q.kind == swcrb_pkg::SWCRB_BYTE_ADDR) begin
								s_d.kind = swcrb_pkg::SWCRB_BYTE_PTR;
							end else begin
								s_d.kind = swcrb_pkg::SWCRB_BYTE_DATA;
							end
						end
					end
				end
				swcrb_pkg::SWCRB_TX: begin
					if (scl_rise) begin
						s_d.cnt = s_q.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_q.cnt == 4'h8) begin
							s_d.st        = swcrb_pkg::SWCRB_TXACK;
							s_d.drive_low = 1'b0;
						end else begin
							s_d.shift     = {s_q.shift[6:0], 1'b0};
							s_d.drive_low = !s_q.shift[6];
						end
					end
				end
				swcrb_pkg::SWCRB_TXACK: begin
					if (scl_rise) begin
						// a not-acknowledge ends the read; only start or stop follows
						if (sda_s) begin
							s_d.st = swcrb_pkg::SWCRB_IDLE;
						end
					end else if (scl_fall) begin
						s_d.st        = swcrb_pkg::SWCRB_TX;
						s_d.cnt       = 4'h0;
						s_d.shift     = rd_byte;
						s_d.ptr       = s_q.ptr + 8'h01;
						s_d.drive_low = !rd_byte[7];
					end
				end
				default: begin
					s_d.st        = swcrb_pkg::SWCRB_IDLE;
					s_d.drive_low = 1'b0;
				end
			endcase
		end

		// --------------------------------------------------------------------
		// control decode, registered towards the video paths
		// --------------------------------------------------------------------
		if (s_q.chan[`SWCRB_BIT_CHANNEL_SOURCE_SEL]) begin
			eff_ch = s_q.chan[1:0];                                             // [R2]
		end else begin
			eff_ch = sel_s;                                                     // [R1]
		end
		manual_term = (s_q.term[7:4] == `SWCRB_TERM_MODE_MANUAL);              // [R9]
		auto_term   = 4'h1 << eff_ch;                                          // [R15]

		s_d.link.active_input = eff_ch;
		if (s_q.outc[`SWCRB_BIT_OUTPUT_GATE_SOURCE]) begin
			s_d.link.output_enable = s_q.outc[`SWCRB_BIT_OUTPUT_ENABLE];        // [R4]
		end else begin
			s_d.link.output_enable = oen_s;                                     // [R3]
		end
		s_d.link.output_current_level  = s_q.outc[`SWCRB_BIT_OUTPUT_CURRENT_LEVEL];  // [R5]
		s_d.link.output_termination_on = s_q.outc[`SWCRB_BIT_OUTPUT_TERMINATION_ON]; // [R6]
		s_d.link.equalizer_boost_sel   = s_q.inc[`SWCRB_BIT_EQUALIZER_BOOST_SEL];    // [R7]
		s_d.link.input_polarity_invert = s_q.inc[`SWCRB_BIT_INPUT_POLARITY_INVERT];  // [R8]
		if (manual_term) begin
			s_d.link.input_termination_on = s_q.term[3:0];                      // [R10]
		end else begin
			s_d.link.input_termination_on = auto_term;                          // [R15]
		end
		s_d.link.display_data_buffer_on =
			s_q.aux[`SWCRB_BIT_DISPLAY_DATA_BUFFER_ON];                         // [R11]
		s_d.link.consumer_control_buffer_on =
			s_q.aux[`SWCRB_BIT_CONSUMER_CTRL_BUFFER_ON];                        // [R12]

		// --------------------------------------------------------------------
		// channel change detect for the hot-plug pulse
		// --------------------------------------------------------------------
		s_d.prev_ch = eff_ch;
		if (eff_ch != s_q.prev_ch) begin
			s_d.hp_start = 1'b1;                                                // [R19]
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q      <= '0;                                                     // [R16]
			s_q.st   <= swcrb_pkg::SWCRB_IDLE;
			s_q.kind <= swcrb_pkg::SWCRB_BYTE_ADDR;
			s_q.chan <= `SWCRB_RST_CHANNEL_SELECT_CTRL;                        // [R16]
			s_q.outc <= `SWCRB_RST_LINK_OUTPUT_CTRL;                           // [R16]
			s_q.inc  <= `SWCRB_RST_LINK_INPUT_CTRL;                            // [R16]
			s_q.term <= `SWCRB_RST_INPUT_TERMINATION_CTRL;                     // [R16]
			s_q.aux  <= `SWCRB_RST_AUX_BUFFER_ENABLES;                         // [R16]
			s_q.pw   <= `SWCRB_RST_HOTPLUG_PULSE_WIDTH;                        // [R16]
			// match the synchroniser's reset level so no false edge follows reset
			s_q.scl_prev <= 1'b0;
			s_q.sda_prev <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------------
	// hot-plug pulse
	// ------------------------------------------------------------------------
	swcrb_hotplug_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_hp (
		.clock   (clock),
		.reset_n (reset_n),
		.start   (s_q.hp_start),
		.steps   (s_q.pw),
		.low     (hp_low)
	);

	// open-drain style: lines are released except during the pulse
	assign hotplug_o  = 4'h0;
	assign hotplug_oe = {4{hp_low}};                                            // [R14]
	assign sda_o      = 1'b0;
	assign sda_oe     = s_q.drive_low;
	assign link       = s_q.link;
endmodule

/* sim/swcrb_i2c_host.sv */
// serial host model driving the register bus with slow open-drain timing
`timescale 1ns/10ps
module swcrb_i2c_host (
	input  wire logic clock,    // system clock
	input  wire logic sda_line, // resolved data wire level
	output logic      scl,      // serial clock drive
	output logic      sda       // data drive, 1 releases to pull-up
);
	// twice the minimum phase, so device edges land well inside low phases
	localparam int HALF = 8;

	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic half();
		repeat (HALF) @(posedge clock);
		#1;
	endtask

	task automatic start();
		sda = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda = 1'b0;
		half();
		scl = 1'b0;
		half();
	endtask

	task automatic stop();
		sda = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda = 1'b1;
		half();
	endtask

	task automatic put_bit(input logic b);
		sda = b;
		half();
		scl = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask

	// msb first, then samples the device acknowledge
	task automatic put_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		sda = 1'b1;
		half();
		scl = 1'b1;
		half();
		ack = !sda_line;
		scl = 1'b0;
		half();
	endtask

	task automatic write(input logic [6:0] a7, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start();
		put_byte({a7, 1'b0}, k0);
		put_byte(p, k1);
		put_byte(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask

	// pointer write, repeated start, one byte read ended by no-acknowledge
	task automatic read(input logic [6:0] a7, input logic [7:0] p, output logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start();
		put_byte({a7, 1'b0}, k0);
		put_byte(p, k1);
		start();
		put_byte({a7, 1'b1}, k2);
		sda = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			scl = 1'b1;
			half();
			d[i] = sda_line;
			scl = 1'b0;
			half();
		end
		put_bit(1'b1);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule

/* sim/swcrb_props.sv */
// port assertions for the switch control register bank
`timescale 1ns/10ps
module swcrb_props #(
	parameter int STEP_CYCLES = 600000
) (
	input wire logic                   clock,      // system clock
	input wire logic                   reset_n,    // reset, active low
	input wire logic                   scl_i,      // serial clock level
	input wire logic                   sda_o,      // data drive value
	input wire logic                   sda_oe,     // data drive enable
	input wire swcrb_pkg::swcrb_link_s link,       // path controls
	input wire logic [3:0]             hotplug_o,  // hot-plug values
	input wire logic [3:0]             hotplug_oe  // hot-plug enables
);
	int unsigned hp_len_q;

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// length of the running hot-plug pulse in clocks
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hp_len_q <= 0;
		end else if (hotplug_oe[0]) begin
			hp_len_q <= hp_len_q + 1;
		end else begin
			hp_len_q <= 0;
		end
	end

	AST_RESET_CLEAR: assert property ($rose(reset_n) |-> link == '0 && !sda_oe)
		else $error("outputs not cleared during reset");
	AST_RESET_DEFAULT: assert property ($rose(reset_n) |=> link.output_current_level
		&& link.output_termination_on && link.equalizer_boost_sel && !link.input_polarity_invert
		&& link.display_data_buffer_on && link.consumer_control_buffer_on)
		else $error("link controls not at defaults after reset");
	AST_SDA_DRIVE_LOW: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data changed while serial clock high");
	AST_ACK_HELD: assert property ($rose(sda_oe) |-> sda_oe [*4])
		else $error("data low drive too short");
	AST_HP_DRIVE_LOW: assert property (hotplug_o == 4'h0)
		else $error("hot-plug value not low");
	AST_HP_ALL_LINES: assert property (hotplug_oe == 4'h0 || hotplug_oe == 4'hf)
		else $error("hot-plug lines not pulsed together");
	AST_HP_ON_SWITCH: assert property ($changed(link.active_input) |-> ##[0:4] hotplug_oe == 4'hf)
		else $error("no hot-plug pulse after channel switch");
	AST_HP_WHOLE_STEPS: assert property ($fell(hotplug_oe[0]) |->
		hp_len_q != 0 && hp_len_q % STEP_CYCLES == 0)
		else $error("hot-plug pulse not whole steps");
endmodule

bind swcrb_top swcrb_props #(.STEP_CYCLES(STEP_CYCLES)) u_swcrb_props (
	.clock      (clock),
	.reset_n    (reset_n),
	.scl_i      (scl_i),
	.sda_o      (sda_o),
	.sda_oe     (sda_oe),
	.link       (link),
	.hotplug_o  (hotplug_o),
	.hotplug_oe (hotplug_oe)
);

/* sim/test_switch_control_register_bank.sv */
// self-checking bench for the switch control register bank
`timescale 1ns/10ps
module test_switch_control_register_bank;
	typedef struct packed {
		logic [7:0] ptr;
		logic [7:0] data;
	} swcrb_row_s;

	logic clock, reset_n, scl, sda, sda_line, sda_o, sda_oe, out_en_pin, ok;
	logic [1:0] addr_strap, sel_pins;
	logic [3:0] hotplug_o, hotplug_oe;
	logic [7:0] d;
	swcrb_pkg::swcrb_link_s link;
	int fail_count, n_compared, cyc, n;
	logic [7:0] rg [6];
	logic [7:0] dflt [6] = '{8'h00, 8'h07, 8'h02, 8'h0f, 8'h07, 8'h05};
	logic [7:0] msk [7] = '{8'h07, 8'h0f, 8'h03, 8'hff, 8'h07, 8'hff, 8'h00};
	swcrb_row_s rows [12] = '{'{8'h00, 8'hff}, '{8'h00, 8'hf9}, '{8'h01, 8'h0b},
		'{8'h01, 8'hfc}, '{8'h02, 8'hfd}, '{8'h02, 8'h02}, '{8'h03, 8'hf5}, '{8'h03, 8'h5a},
		'{8'h04, 8'hfc}, '{8'h04, 8'h07}, '{8'h05, 8'h06}, '{8'h06, 8'ha5}};

	assign sda_line = sda & !sda_oe;

	swcrb_top #(.STEP_CYCLES(10)) u_swcrb_top (
		.clock      (clock),
		.reset_n    (reset_n),
		.scl_i      (scl),
		.sda_i      (sda_line),
		.sda_o      (sda_o),
		.sda_oe     (sda_oe),
		.addr_strap (addr_strap),
		.sel_pins   (sel_pins),
		.out_en_pin (out_en_pin),
		.link       (link),
		.hotplug_o  (hotplug_o),
		.hotplug_oe (hotplug_oe)
	);

	swcrb_i2c_host u_swcrb_i2c_host (
		.clock    (clock),
		.sda_line (sda_line),
		.scl      (scl),
		.sda      (sda)
	);

	function automatic logic [6:0] dev_addr();
		return {5'h12, addr_strap};
	endfunction

	function automatic swcrb_pkg::swcrb_link_s exp_link();
		swcrb_pkg::swcrb_link_s e;
		logic [1:0] ch;
		ch = rg[0][2] ? rg[0][1:0] : sel_pins;
		e.active_input = ch;
		e.output_enable = rg[1][3] ? rg[1][2] : out_en_pin;
		e.output_current_level = rg[1][1];
		e.output_termination_on = rg[1][0];
		e.equalizer_boost_sel = rg[2][1];
		e.input_polarity_invert = rg[2][0];
		e.input_termination_on = (rg[3][7:4] == 4'hf) ? rg[3][3:0] : 4'h1 << ch;
		e.display_data_buffer_on = rg[4][1];
		e.consumer_control_buffer_on = rg[4][0];
		return e;
	endfunction

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wait_clk(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask

	// cycles of one hot-plug pulse, waiting a bounded time for its start
	task automatic hp_measure(output int len);
		int w;
		w = 0;
		len = 0;
		while (hotplug_oe !== 4'hf && w < 200) begin
			wait_clk(1);
			w++;
		end
		do begin
			wait_clk(1);
			len++;
		end while (hotplug_oe === 4'hf && len < 1000);
	endtask

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			$display("MISMATCH run length expected finish seen hang");
			results();
		end
	end

	initial begin
		reset_n = 1'b0;
		addr_strap = 2'h0;
		sel_pins = 2'h0;
		out_en_pin = 1'b1;
		rg = dflt;
		wait_clk(5);
		reset_n = 1'b1;
		wait_clk(4);
		sel_pins = 2'h2;
		wait_clk(8);
		chk("pin channel link", exp_link(), link);
		foreach (rows[i]) begin
			u_swcrb_i2c_host.write(dev_addr(), rows[i].ptr, rows[i].data, ok);
			chk("write ack", 1'b1, ok);
			if (rows[i].ptr < 6) rg[rows[i].ptr] = rows[i].data & msk[rows[i].ptr];
			u_swcrb_i2c_host.read(dev_addr(), rows[i].ptr, d, ok);
			chk("readback", rows[i].data & msk[rows[i].ptr], d);
			chk("link", exp_link(), link);
		end
		// pin-gated output enable after returning the output gate source to the pin
		u_swcrb_i2c_host.write(dev_addr(), 8'h01, 8'h07, ok);
		rg[1] = 8'h07;
		out_en_pin = 1'b0;
		wait_clk(6);
		chk("pin output enable", exp_link(), link);
		// pulse width from a pin switch: register 05 holds 6 steps of 10 clocks
		sel_pins = 2'h1;
		hp_measure(n);
		chk("hot-plug length", 16'd60, n[15:0]);
		u_swcrb_i2c_host.write({5'h12, ~addr_strap}, 8'h05, 8'h33, ok);
		chk("foreign address ack", 1'b0, ok);
		addr_strap = 2'h3;
		wait_clk(6);
		u_swcrb_i2c_host.write(dev_addr(), 8'h05, 8'h02, ok);
		chk("strap address ack", 1'b1, ok);
		sel_pins = 2'h3;
		hp_measure(n);
		chk("hot-plug short", 16'd20, n[15:0]);
		// reset in mid-run restores every register
		reset_n = 1'b0;
		wait_clk(2);
		chk("link in reset", 16'h0000, link);
		reset_n = 1'b1;
		rg = dflt;
		wait_clk(4);
		for (int i = 0; i < 6; i++) begin
			u_swcrb_i2c_host.read(dev_addr(), i[7:0], d, ok);
			chk("reset default", dflt[i], d);
		end
		chk("link after reset", exp_link(), link);
		results();
	end
endmodule
